// ==== verilog/bram_pkg.sv ====
`default_nettype none
package bram_pkg;

  // ****************************************************************
  // storage shape
  // ****************************************************************
  localparam int DATA_BITS   = 16384;
  localparam int PAR_BITS    = 2048;
  localparam int DATA_ADDR_W = 14;
  localparam int PAR_ADDR_W  = 11;
  localparam int MAX_DW      = 32;
  localparam int MAX_PW      = 4;
  localparam int PAR_GROUP   = 9;
  localparam int PAR_DATA    = 8;

  // ****************************************************************
  // port widths
  // ****************************************************************
  localparam int WIDTH_1  = 1;
  localparam int WIDTH_2  = 2;
  localparam int WIDTH_4  = 4;
  localparam int WIDTH_9  = 9;
  localparam int WIDTH_18 = 18;
  localparam int WIDTH_36 = 36;

  // ****************************************************************
  // write behaviour of the output register
  // ****************************************************************
  typedef enum logic [1:0] {
    WRITE_THROUGH     = 2'h0,
    READ_BEFORE_WRITE = 2'h1,
    HOLD_OUTPUT       = 2'h3
  } write_mode_e;

  // data bits of one word for a port width
  function automatic int data_width(input int w);
    return (w >= PAR_GROUP) ? (w / PAR_GROUP) * PAR_DATA : w;
  endfunction : data_width

  // parity bits of one word for a port width
  function automatic int par_width(input int w);
    return (w >= PAR_GROUP) ? w / PAR_GROUP : 0;
  endfunction : par_width

endpackage : bram_pkg
`default_nettype wire

// ==== verilog/ram_port_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface ram_port_if;
  logic        en;
  logic        we;
  logic        sync_output_set_reset;
  logic [31:0] wdata;
  logic [3:0]  wpar;
  logic [31:0] rdata;
  logic [3:0]  rpar;
  logic [31:0] dout;
  logic [3:0]  pout;

  modport core (
    output en, we, sync_output_set_reset, wdata, wpar, rdata, rpar,
    input  dout, pout
  );
  modport outreg (
    input  en, we, sync_output_set_reset, wdata, wpar, rdata, rpar,
    output dout, pout
  );
endinterface : ram_port_if
`default_nettype wire

// ==== verilog/port_out_reg.sv ====
`timescale 1ns/1ns
`default_nettype none
module port_out_reg #(
  parameter bram_pkg::write_mode_e MODE     = bram_pkg::WRITE_THROUGH,
  parameter logic [31:0]           OUTPUT_SET_VALUE_D  = 32'h0000_0000,
  parameter logic [3:0]            OUTPUT_SET_VALUE_P  = 4'h0,
  parameter logic [31:0]           INIT_D   = 32'h0000_0000,
  parameter logic [3:0]            INIT_P   = 4'h0
) (
  input wire logic  clk,
  input wire logic  rst,
  ram_port_if.outreg p
);

  logic [31:0] dout_q;
  logic [31:0] dout_d;
  logic [3:0]  pout_q;
  logic [3:0]  pout_d;
  logic        wr_edge;
  logic        rd_edge;

  // ****************************************************************
  // next value of the output register
  // ****************************************************************
  assign wr_edge = p.en && !p.sync_output_set_reset && p.we;
  assign rd_edge = p.en && !p.sync_output_set_reset && !p.we;

  always_comb begin
    dout_d = dout_q;
    pout_d = pout_q;
    if (!p.en) begin
      dout_d = dout_q;
    end else if (p.sync_output_set_reset) begin
      dout_d = OUTPUT_SET_VALUE_D;
      pout_d = OUTPUT_SET_VALUE_P;
    end else if (!p.we) begin
      dout_d = p.rdata;
      pout_d = p.rpar;
    end else begin
      case (MODE)
        bram_pkg::WRITE_THROUGH: begin
          dout_d = p.wdata;
          pout_d = p.wpar;
        end
        bram_pkg::READ_BEFORE_WRITE: begin
          dout_d = p.rdata;
          pout_d = p.rpar;
        end
        default: begin
          dout_d = dout_q;
          pout_d = pout_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dout_q <= INIT_D;
      pout_q <= INIT_P;
    end else begin
      dout_q <= dout_d;
      pout_q <= pout_d;
    end
  end

  assign p.dout = dout_q;
  assign p.pout = pout_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_set_edge;
    p.en && p.sync_output_set_reset;
  endsequence

  sequence s_write_edge;
    p.en && !p.sync_output_set_reset && p.we;
  endsequence

  a_disabled_hold: assert property (@(posedge clk) disable iff (rst)
    !p.en |=> $stable(dout_q) && $stable(pout_q))
    else $error("output changed while port disabled");

  a_set_value: assert property (@(posedge clk) disable iff (rst)
    s_set_edge |=> dout_q == OUTPUT_SET_VALUE_D && pout_q == OUTPUT_SET_VALUE_P)
    else $error("set/reset value not loaded");

  a_read_load: assert property (@(posedge clk) disable iff (rst)
    rd_edge |=> dout_q == $past(p.rdata) && pout_q == $past(p.rpar))
    else $error("read word not loaded");

  a_write_through: assert property (@(posedge clk) disable iff (rst)
    s_write_edge ##0 (MODE == bram_pkg::WRITE_THROUGH)
      |=> dout_q == $past(p.wdata) && pout_q == $past(p.wpar))
    else $error("written word not passed through");

  a_read_first: assert property (@(posedge clk) disable iff (rst)
    s_write_edge ##0 (MODE == bram_pkg::READ_BEFORE_WRITE)
      |=> dout_q == $past(p.rdata))
    else $error("old content not returned on write");

  a_hold_output: assert property (@(posedge clk) disable iff (rst)
    s_write_edge ##0 (MODE == bram_pkg::HOLD_OUTPUT)
      |=> $stable(dout_q) && $stable(pout_q))
    else $error("output changed on write in hold mode");

endmodule : port_out_reg
`default_nettype wire

// ==== verilog/dual_port_block_ram.sv ====
`timescale 1ns/1ns
`default_nettype none
module dual_port_block_ram #(
  parameter int                    WIDTH_A    = bram_pkg::WIDTH_36,
  parameter int                    WIDTH_B    = bram_pkg::WIDTH_36,
  parameter bram_pkg::write_mode_e MODE_A     = bram_pkg::WRITE_THROUGH,
  parameter bram_pkg::write_mode_e MODE_B     = bram_pkg::WRITE_THROUGH,
  parameter logic                  CLK_INV    = 1'b0,
  parameter logic                  EN_A_INV   = 1'b0,
  parameter logic                  WE_A_INV   = 1'b0,
  parameter logic                  SSR_A_INV  = 1'b0,
  parameter logic                  EN_B_INV   = 1'b0,
  parameter logic                  WE_B_INV   = 1'b0,
  parameter logic                  SSR_B_INV  = 1'b0,
  parameter logic [31:0]           OUTPUT_SET_VALUE_A_D  = 32'h0000_0000,
  parameter logic [3:0]            OUTPUT_SET_VALUE_A_P  = 4'h0,
  parameter logic [31:0]           OUTPUT_SET_VALUE_B_D  = 32'h0000_0000,
  parameter logic [3:0]            OUTPUT_SET_VALUE_B_P  = 4'h0,
  parameter logic [31:0]           INIT_A_D   = 32'h0000_0000,
  parameter logic [3:0]            INIT_A_P   = 4'h0,
  parameter logic [31:0]           INIT_B_D   = 32'h0000_0000,
  parameter logic [3:0]            INIT_B_P   = 4'h0,
  parameter logic [16383:0]        MEMORY_INITIAL_CONTENTS = '0,
  parameter logic [2047:0]         MEMORY_INITIAL_PARITY   = '0
) (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        PORT_A_ENABLE,
  input  wire logic        PORT_A_WRITE_ENABLE,
  input  wire logic        PORT_A_SYNC_OUTPUT_SET_RESET,
  input  wire logic [13:0] PORT_A_ADDR,
  input  wire logic [31:0] PORT_A_WRITE_DATA_IN,
  input  wire logic [3:0]  PORT_A_WRITE_PARITY_IN,
  output var  logic [31:0] PORT_A_DATA_OUT,
  output var  logic [3:0]  PORT_A_PARITY_OUT,
  input  wire logic        PORT_B_ENABLE,
  input  wire logic        PORT_B_WRITE_ENABLE,
  input  wire logic        PORT_B_SYNC_OUTPUT_SET_RESET,
  input  wire logic [13:0] PORT_B_ADDR,
  input  wire logic [31:0] PORT_B_WRITE_DATA_IN,
  input  wire logic [3:0]  PORT_B_WRITE_PARITY_IN,
  output var  logic [31:0] PORT_B_DATA_OUT,
  output var  logic [3:0]  PORT_B_PARITY_OUT
);

  // ****************************************************************
  // port shapes
  // ****************************************************************
  localparam int DW_A = bram_pkg::data_width(WIDTH_A);
  localparam int PW_A = bram_pkg::par_width(WIDTH_A);
  localparam int DW_B = bram_pkg::data_width(WIDTH_B);
  localparam int PW_B = bram_pkg::par_width(WIDTH_B);

  logic mem_clk;
  logic data_mem [bram_pkg::DATA_BITS];
  logic par_mem  [bram_pkg::PAR_BITS];

  logic        en_a;
  logic        we_a;
  logic        ssr_a;
  logic        en_b;
  logic        we_b;
  logic        ssr_b;
  logic        wr_a;
  logic        wr_b;
  logic [13:0] didx_a;
  logic [13:0] didx_b;
  logic [10:0] pidx_a;
  logic [10:0] pidx_b;

  ram_port_if a_if ();
  ram_port_if b_if ();

  // ****************************************************************
  // configured polarities
  // ****************************************************************
  assign mem_clk = CLK ^ CLK_INV;
  assign en_a    = PORT_A_ENABLE ^ EN_A_INV;
  assign we_a    = PORT_A_WRITE_ENABLE ^ WE_A_INV;
  assign ssr_a   = PORT_A_SYNC_OUTPUT_SET_RESET ^ SSR_A_INV;
  assign en_b    = PORT_B_ENABLE ^ EN_B_INV;
  assign we_b    = PORT_B_WRITE_ENABLE ^ WE_B_INV;
  assign ssr_b   = PORT_B_SYNC_OUTPUT_SET_RESET ^ SSR_B_INV;

  assign wr_a = en_a && we_a;
  assign wr_b = en_b && we_b;

  // ****************************************************************
  // bit positions; upper address bits wrap out by truncation
  // ****************************************************************
  assign didx_a = 14'(PORT_A_ADDR * DW_A);
  assign didx_b = 14'(PORT_B_ADDR * DW_B);
  assign pidx_a = 11'(PORT_A_ADDR * PW_A);
  assign pidx_b = 11'(PORT_B_ADDR * PW_B);

  assign a_if.en  = en_a;
  assign a_if.we  = we_a;
  assign a_if.sync_output_set_reset = ssr_a;
  assign b_if.en  = en_b;
  assign b_if.we  = we_b;
  assign b_if.sync_output_set_reset = ssr_b;

  // ****************************************************************
  // per-bit read and write-data lanes
  // ****************************************************************
  for (genvar i = 0; i < bram_pkg::MAX_DW; i++) begin : g_dbit
    if (i < DW_A) begin : g_a
      assign a_if.rdata[i] = data_mem[14'(didx_a + i)];
      assign a_if.wdata[i] = PORT_A_WRITE_DATA_IN[i];
    end else begin : g_a0
      assign a_if.rdata[i] = 1'b0;
      assign a_if.wdata[i] = 1'b0;
    end
    if (i < DW_B) begin : g_b
      assign b_if.rdata[i] = data_mem[14'(didx_b + i)];
      assign b_if.wdata[i] = PORT_B_WRITE_DATA_IN[i];
    end else begin : g_b0
      assign b_if.rdata[i] = 1'b0;
      assign b_if.wdata[i] = 1'b0;
    end
  end

  for (genvar i = 0; i < bram_pkg::MAX_PW; i++) begin : g_pbit
    if (i < PW_A) begin : g_a
      assign a_if.rpar[i] = par_mem[11'(pidx_a + i)];
      assign a_if.wpar[i] = PORT_A_WRITE_PARITY_IN[i];
    end else begin : g_a0
      assign a_if.rpar[i] = 1'b0;
      assign a_if.wpar[i] = 1'b0;
    end
    if (i < PW_B) begin : g_b
      assign b_if.rpar[i] = par_mem[11'(pidx_b + i)];
      assign b_if.wpar[i] = PORT_B_WRITE_PARITY_IN[i];
    end else begin : g_b0
      assign b_if.rpar[i] = 1'b0;
      assign b_if.wpar[i] = 1'b0;
    end
  end

  // ****************************************************************
  // storage; preload, then writes from both ports
  // ****************************************************************
  initial begin
    for (int k = 0; k < bram_pkg::DATA_BITS; k++) begin
      data_mem[k] = MEMORY_INITIAL_CONTENTS[k];
    end
    for (int k = 0; k < bram_pkg::PAR_BITS; k++) begin
      par_mem[k] = MEMORY_INITIAL_PARITY[k];
    end
  end

  // on a same-cycle collision the port with the higher lane index for a bit lands last; port b on an equal index
  always @(posedge mem_clk) begin
    for (int k = 0; k < bram_pkg::MAX_DW; k++) begin
      if (wr_a && k < DW_A) begin
        data_mem[14'(didx_a + k)] <= PORT_A_WRITE_DATA_IN[k];
      end
      if (wr_b && k < DW_B) begin
        data_mem[14'(didx_b + k)] <= PORT_B_WRITE_DATA_IN[k];
      end
    end
    for (int k = 0; k < bram_pkg::MAX_PW; k++) begin
      if (wr_a && k < PW_A) begin
        par_mem[11'(pidx_a + k)] <= PORT_A_WRITE_PARITY_IN[k];
      end
      if (wr_b && k < PW_B) begin
        par_mem[11'(pidx_b + k)] <= PORT_B_WRITE_PARITY_IN[k];
      end
    end
  end

  // ****************************************************************
  // output registers
  // ****************************************************************
  port_out_reg #(
    .MODE    (MODE_A),
    .OUTPUT_SET_VALUE_D (OUTPUT_SET_VALUE_A_D),
    .OUTPUT_SET_VALUE_P (OUTPUT_SET_VALUE_A_P),
    .INIT_D  (INIT_A_D),
    .INIT_P  (INIT_A_P)
  ) u_out_a (
    .clk (mem_clk),
    .rst (SYS_RST),
    .p   (a_if.outreg)
  );

  port_out_reg #(
    .MODE    (MODE_B),
    .OUTPUT_SET_VALUE_D (OUTPUT_SET_VALUE_B_D),
    .OUTPUT_SET_VALUE_P (OUTPUT_SET_VALUE_B_P),
    .INIT_D  (INIT_B_D),
    .INIT_P  (INIT_B_P)
  ) u_out_b (
    .clk (mem_clk),
    .rst (SYS_RST),
    .p   (b_if.outreg)
  );

  assign PORT_A_DATA_OUT   = a_if.dout;
  assign PORT_A_PARITY_OUT = a_if.pout;
  assign PORT_B_DATA_OUT   = b_if.dout;
  assign PORT_B_PARITY_OUT = b_if.pout;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_store_data: assert property (@(posedge mem_clk) disable iff (SYS_RST)
    wr_a && !wr_b |=> data_mem[$past(didx_a)] ==
      $past(PORT_A_WRITE_DATA_IN[0]))
    else $error("port a write not stored");

  a_store_parity: assert property (@(posedge mem_clk) disable iff (SYS_RST)
    wr_b && !wr_a && (PW_B > 0) |=> par_mem[$past(pidx_b)] ==
      $past(PORT_B_WRITE_PARITY_IN[0]))
    else $error("port b parity not stored");

  a_no_store_off: assert property (@(posedge mem_clk) disable iff (SYS_RST)
    !en_a && !wr_b |=> data_mem[$past(didx_a)] ==
      $past(data_mem[didx_a]))
    else $error("storage changed with port disabled");

endmodule : dual_port_block_ram
`default_nettype wire

// ==== dv/user_port_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module user_port_model #(
  parameter logic EN_INV  = 1'b0,
  parameter logic WE_INV  = 1'b0,
  parameter logic SSR_INV = 1'b0
) (
  output var logic        en,
  output var logic        we,
  output var logic        sync_output_set_reset,
  output var logic [13:0] addr,
  output var logic [31:0] wdata,
  output var logic [3:0]  wpar
);
  // ********
  // requests
  // ********
  // called only just after a rising edge
  task automatic req(input logic e, input logic w, input logic s,
                     input logic [13:0] a, input logic [31:0] d,
                     input logic [3:0] p);
    en    = e ^ EN_INV;
    we    = w ^ WE_INV;
    sync_output_set_reset   = s ^ SSR_INV;
    addr  = a;
    wdata = d;
    wpar  = p;
  endtask : req
  // released lines flip so stale values never look valid
  task automatic idle();
    en    = EN_INV;
    we    = WE_INV;
    sync_output_set_reset   = SSR_INV;
    addr  = ~addr;
    wdata = ~wdata;
    wpar  = ~wpar;
  endtask : idle
  initial begin
    addr  = 14'h0000;
    wdata = 32'h0000_0000;
    wpar  = 4'h0;
    idle();
  end
endmodule : user_port_model
`default_nettype wire

// ==== dv/dual_port_block_ram_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
  n_mismatch++; $display("Error %s expected %0h seen %0h", nm, ex, got); \
  end end
module dual_port_block_ram_tb;
  localparam logic [31:0] PAT  = 32'hA5C3_0F1E;
  localparam logic [3:0]  PPAT = 4'h9;
  localparam logic        INV_ON = 1'b1;
  localparam logic [31:0] SRA_D  = 32'hDEAD_BEEF;
  localparam logic [3:0]  SRA_P  = 4'hA;
  localparam logic [31:0] SRB_D  = 32'h0000_005A;
  localparam logic [3:0]  SRB_P  = 4'h0;
  localparam logic [31:0] INA_D  = 32'h1234_5678;
  localparam logic [3:0]  INA_P  = 4'h5;
  localparam logic [31:0] INB_D  = 32'h0000_00C7;
  localparam logic [3:0]  INB_P  = 4'h1;
  logic             CLK        = 1'b0;
  logic             SYS_RST    = 1'b1;
  int               n_mismatch = 0;
  int               n_checks   = 0;
  int               cyc        = 0;
  wire logic        ena, port_a_write_enable, ssra, port_b_enable, port_b_write_enable, ssrb;
  wire logic [13:0] adra, adrb;
  wire logic [31:0] wda, wdb, qa, qb;
  wire logic [3:0]  wpa, wpb, pa, pb;
  // ********
  // clock, timeout, instances
  // ********
  always #50 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      final_report();
    end
  end
  user_port_model #(.WE_INV(INV_ON)) ua (.en(ena), .we(port_a_write_enable), .sync_output_set_reset(ssra),
    .addr(adra), .wdata(wda), .wpar(wpa));
  user_port_model #(.EN_INV(INV_ON), .SSR_INV(INV_ON)) ub (.en(port_b_enable),
    .we(port_b_write_enable), .sync_output_set_reset(ssrb), .addr(adrb), .wdata(wdb), .wpar(wpb));
  dual_port_block_ram #(
    .WIDTH_A(bram_pkg::WIDTH_36), .WIDTH_B(bram_pkg::WIDTH_9),
    .MODE_A(bram_pkg::READ_BEFORE_WRITE), .MODE_B(bram_pkg::HOLD_OUTPUT),
    .WE_A_INV(INV_ON), .EN_B_INV(INV_ON), .SSR_B_INV(INV_ON),
    .OUTPUT_SET_VALUE_A_D(SRA_D), .OUTPUT_SET_VALUE_A_P(SRA_P),
    .OUTPUT_SET_VALUE_B_D(SRB_D), .OUTPUT_SET_VALUE_B_P(SRB_P),
    .INIT_A_D(INA_D), .INIT_A_P(INA_P),
    .INIT_B_D(INB_D), .INIT_B_P(INB_P),
    .MEMORY_INITIAL_CONTENTS({512{PAT}}),
    .MEMORY_INITIAL_PARITY({512{PPAT}})
  ) dual_port_block_ram_inst (
    .CLK(CLK), .SYS_RST(SYS_RST),
    .PORT_A_ENABLE(ena), .PORT_A_WRITE_ENABLE(port_a_write_enable),
    .PORT_A_SYNC_OUTPUT_SET_RESET(ssra), .PORT_A_ADDR(adra),
    .PORT_A_WRITE_DATA_IN(wda), .PORT_A_WRITE_PARITY_IN(wpa),
    .PORT_A_DATA_OUT(qa), .PORT_A_PARITY_OUT(pa),
    .PORT_B_ENABLE(port_b_enable), .PORT_B_WRITE_ENABLE(port_b_write_enable),
    .PORT_B_SYNC_OUTPUT_SET_RESET(ssrb), .PORT_B_ADDR(adrb),
    .PORT_B_WRITE_DATA_IN(wdb), .PORT_B_WRITE_PARITY_IN(wpb),
    .PORT_B_DATA_OUT(qb), .PORT_B_PARITY_OUT(pb));
  // ********
  // helpers
  // ********
  task automatic tick();
    @(posedge CLK);
    #10;
  endtask : tick
  task automatic chk(input string nm, input logic [35:0] ex,
                     input logic [35:0] got);
    `CK(nm, ex, got)
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  // ********
  // scenarios
  // ********
  task automatic t_reset();
    chk("a init", {INA_P, INA_D}, {pa, qa});
    chk("b init", {INB_P, INB_D}, {pb, qb});
    $display("t_reset done");
  endtask : t_reset
  task automatic t_preload();
    ua.req(1, 0, 0, 14'h0003, 32'h0, 4'h0);
    ub.req(1, 0, 0, 14'h0005, 32'h0, 4'h0);
    tick();
    chk("a preload", {PPAT, PAT}, {pa, qa});
    chk("b preload", {4'h0, 32'h0F}, {pb, qb});
    $display("t_preload done");
  endtask : t_preload
  task automatic t_rbw();
    ua.req(1, 1, 0, 14'h0007, 32'h8765_4321, 4'h6);
    ub.idle();
    tick();
    chk("a rbw", {PPAT, PAT}, {pa, qa});
    ua.req(1, 0, 0, 14'h0007, 32'h0, 4'h0);
    tick();
    chk("a rd7", {4'h6, 32'h8765_4321}, {pa, qa});
    ua.idle();
    ub.req(1, 0, 0, 14'h001C, 32'h0, 4'h0);
    tick();
    chk("b rd28", {4'h0, 32'h21}, {pb, qb});
    ub.req(1, 0, 0, 14'h001D, 32'h0, 4'h0);
    tick();
    chk("b rd29", {4'h1, 32'h43}, {pb, qb});
    $display("t_rbw done");
  endtask : t_rbw
  task automatic t_hold();
    ub.req(1, 0, 0, 14'h0002, 32'h0, 4'h0);
    tick();
    chk("b rd2", {4'h0, 32'hC3}, {pb, qb});
    ub.req(1, 1, 0, 14'h0002, 32'h3C, 4'h1);
    tick();
    chk("b hold", {4'h0, 32'hC3}, {pb, qb});
    ub.idle();
    ua.req(1, 0, 0, 14'h0000, 32'h0, 4'h0);
    tick();
    chk("a rd0", {4'hD, 32'hA53C_0F1E}, {pa, qa});
    $display("t_hold done");
  endtask : t_hold
  task automatic t_enable();
    ua.req(0, 1, 1, 14'h0000, 32'hFFFF_FFFF, 4'hF);
    ub.req(0, 1, 1, 14'h0002, 32'hFF, 4'h1);
    tick();
    chk("a off", {4'hD, 32'hA53C_0F1E}, {pa, qa});
    chk("b off", {4'h0, 32'hC3}, {pb, qb});
    ua.req(1, 0, 0, 14'h0000, 32'h0, 4'h0);
    ub.req(1, 0, 0, 14'h0002, 32'h0, 4'h0);
    tick();
    chk("a kept", {4'hD, 32'hA53C_0F1E}, {pa, qa});
    chk("b kept", {4'h1, 32'h3C}, {pb, qb});
    $display("t_enable done");
  endtask : t_enable
  task automatic t_ssr();
    ua.req(1, 1, 1, 14'h0009, 32'h1111_1111, 4'h3);
    ub.req(1, 0, 1, 14'h0006, 32'h0, 4'h0);
    tick();
    chk("a set", {SRA_P, SRA_D}, {pa, qa});
    chk("b set", {SRB_P, SRB_D}, {pb, qb});
    ua.req(1, 0, 0, 14'h0009, 32'h0, 4'h0);
    ub.idle();
    tick();
    chk("a rd9", {4'h3, 32'h1111_1111}, {pa, qa});
    #80;
    chk("a stands", {4'h3, 32'h1111_1111}, {pa, qa});
    tick();
    $display("t_ssr done");
  endtask : t_ssr
  task automatic t_rst2();
    ua.idle();
    SYS_RST = 1'b1;
    tick();
    SYS_RST = 1'b0;
    chk("a reinit", {INA_P, INA_D}, {pa, qa});
    ua.req(1, 0, 0, 14'h0007, 32'h0, 4'h0);
    tick();
    chk("a after rst", {4'h6, 32'h8765_4321}, {pa, qa});
    $display("t_rst2 done");
  endtask : t_rst2
  initial begin
    repeat (12) @(posedge CLK);
    #10;
    SYS_RST = 1'b0;
    t_reset();
    t_preload();
    t_rbw();
    t_hold();
    t_enable();
    t_ssr();
    t_rst2();
    final_report();
  end
endmodule : dual_port_block_ram_tb
`default_nettype wire
